// >>> core/e1_perf_monitor.sv
/*
  E1 performance monitor: four error counters latched per interval,
  status flags, two interrupt masks and an Avalon-MM slave.
  Assumes framer strobes arrive on i_clk as single-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "e1_perf_consts.svh"
module e1_perf_monitor #(
  parameter int unsigned LONG_CYCLES  = `LONG_INTERVAL_NS / `CLK_PERIOD_NS,
  parameter int unsigned SHORT_CYCLES = (`SHORT_INTERVAL_US * 1000) / `CLK_PERIOD_NS
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [8:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_rx_bit_valid,
  input  wire logic        i_rx_pos,
  input  wire logic        i_rx_neg,
  input  wire logic        i_crc_error,
  input  wire logic        i_ebit_strobe,
  input  wire logic        i_ebit,
  input  wire logic        i_fas_word_error,
  input  wire logic        i_fas_sync_lost,
  input  wire logic        i_crc_sync_lost,
  input  wire logic        i_sync_search,
  input  wire logic [7:0]  i_rx_status_events,
  input  wire logic [7:0]  i_frame_events,
  output logic             o_irq
);
  localparam int TW = $clog2(LONG_CYCLES + 1);
  localparam logic [TW-1:0] LONG_LIM  = TW'(LONG_CYCLES - 1);
  localparam logic [TW-1:0] SHORT_LIM = TW'(SHORT_CYCLES - 1);

  function automatic int cnt_width(input int n);
    unique case (n)
      0:       cnt_width = 16;
      3:       cnt_width = 12;
      default: cnt_width = 10;
    endcase
  endfunction

  function automatic logic hit(input logic [6:0] idx, input logic [6:0] want);
    hit = (idx == want);
  endfunction

  e1_perf_pkg::bus_state_t state_r;
  logic [7:0]              ctrl_r;
  logic [7:0]              rx_mask_r;
  logic [7:0]              ev_mask_r;
  logic [7:0]              rx_flags_r;
  logic [7:0]              ev_flags_r;
  logic [7:0]              rx_flags_nxt;
  logic [7:0]              ev_flags_nxt;
  logic [7:0]              rd_byte;
  logic [6:0]              idx;
  logic                    wr_fire;
  logic [TW-1:0]           tmr_r;
  logic [TW-1:0]           tmr_lim;
  logic                    tick_r;
  logic                    last_mark_pos_r;
  logic                    last_viol_pos_r;
  logic                    seen_mark_r;
  logic                    seen_viol_r;
  logic [1:0]              zero_run_r;
  logic                    mark;
  logic                    bipolar_violation;
  logic                    subst_v;
  logic                    cv;
  logic                    viol_inc;
  logic                    crc_inc;
  logic                    feb_inc;
  logic                    fas_inc;
  logic                    crc_ok;
  logic [3:0]              inc_vec;
  e1_perf_pkg::count_t     held [4];

  assign idx     = i_avs_address[8:2];
  assign wr_fire = (state_r == e1_perf_pkg::BUS_ACK) && i_avs_write && i_avs_byteenable[0];

  // ==========================================================
  // Interval timer
  assign tmr_lim = ctrl_r[`SHORT_SEL_BIT] ? SHORT_LIM : LONG_LIM;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tmr_r  <= '0;
      tick_r <= 1'b0;
    end else if (tmr_r >= tmr_lim) begin
      tmr_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      tmr_r  <= tmr_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Line violation detection
  assign mark    = i_rx_bit_valid && (i_rx_pos || i_rx_neg);
  // No polarity to compare against until the first mark after reset
  assign bipolar_violation     = mark && seen_mark_r && (i_rx_pos == last_mark_pos_r);
  // B00V and 000V both leave two or more zeros before the V
  assign subst_v = ctrl_r[`ZSUB_BIT] && (zero_run_r >= 2'd2);
  assign cv      = bipolar_violation && seen_viol_r && (i_rx_pos == last_viol_pos_r);
  assign viol_inc = ctrl_r[`VTYPE_BIT] ? cv : (bipolar_violation && !subst_v);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_mark_pos_r <= 1'b0;
      seen_mark_r     <= 1'b0;
      zero_run_r      <= 2'd0;
    end else if (i_rx_bit_valid) begin
      if (mark) begin
        last_mark_pos_r <= i_rx_pos;
        seen_mark_r     <= 1'b1;
        zero_run_r      <= 2'd0;
      end else if (zero_run_r != 2'd3) begin
        zero_run_r <= zero_run_r + 2'd1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      last_viol_pos_r <= 1'b0;
      seen_viol_r     <= 1'b0;
    end else if (bipolar_violation) begin
      last_viol_pos_r <= i_rx_pos;
      seen_viol_r     <= 1'b1;
    end
  end

  // ==========================================================
  // Counter gating
  assign crc_ok  = !i_fas_sync_lost && !i_crc_sync_lost;
  assign crc_inc = i_crc_error && crc_ok;
  assign feb_inc = i_ebit_strobe && !i_ebit && crc_ok;
  assign fas_inc = i_fas_word_error && !i_fas_sync_lost && !i_sync_search;
  assign inc_vec = {fas_inc, feb_inc, crc_inc, viol_inc};

  err_count_if cnt_if [4] ();

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cnt
      assign cnt_if[g].inc      = inc_vec[g];
      assign cnt_if[g].boundary = tick_r;
      assign held[g]            = cnt_if[g].held;
      sat_counter #(
        .WIDTH (cnt_width(g))
      ) u_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .port      (cnt_if[g])
      );
    end
  endgenerate

  // ==========================================================
  // Control and mask registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_fire && hit(idx, `CTRL_IDX)) begin
      ctrl_r <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_mask_r <= `MASK_RESET;
      ev_mask_r <= `MASK_RESET;
    end else if (wr_fire) begin
      if (hit(idx, `RX_MASK_IDX)) begin
        rx_mask_r <= i_avs_writedata[7:0];
      end
      if (hit(idx, `EV_MASK_IDX)) begin
        ev_mask_r <= i_avs_writedata[7:0];
      end
    end
  end

  // ==========================================================
  // Status flags, write one to clear; a new event beats the clear
  always_comb begin
    rx_flags_nxt = rx_flags_r;
    ev_flags_nxt = ev_flags_r;
    if (wr_fire && hit(idx, `RX_STATUS_IDX)) begin
      rx_flags_nxt = rx_flags_nxt & ~i_avs_writedata[7:0];
    end
    if (wr_fire && hit(idx, `EV_STATUS_IDX)) begin
      ev_flags_nxt = ev_flags_nxt & ~i_avs_writedata[7:0];
    end
    rx_flags_nxt = rx_flags_nxt | i_rx_status_events;
    ev_flags_nxt = ev_flags_nxt | i_frame_events;
    ev_flags_nxt[`TIMER_FLAG_BIT] = ev_flags_nxt[`TIMER_FLAG_BIT] | tick_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_flags_r <= 8'h00;
      ev_flags_r <= 8'h00;
    end else begin
      rx_flags_r <= rx_flags_nxt;
      ev_flags_r <= ev_flags_nxt;
    end
  end

  // Zero mask bit blocks its flag from the request line
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(rx_flags_nxt & rx_mask_r) || |(ev_flags_nxt & ev_mask_r);
    end
  end

  // ==========================================================
  // Read decode
  always_comb begin
    unique case (idx)
      `VIOL_HI_IDX:   rd_byte = held[0][15:8];
      `VIOL_LO_IDX:   rd_byte = held[0][7:0];
      `CRC_HI_IDX:    rd_byte = {held[3][11:6], held[1][9:8]};
      `CRC_LO_IDX:    rd_byte = held[1][7:0];
      `FEB_HI_IDX:    rd_byte = {held[3][5:0], held[2][9:8]};
      `FEB_LO_IDX:    rd_byte = held[2][7:0];
      `RX_STATUS_IDX: rd_byte = rx_flags_r;
      `EV_STATUS_IDX: rd_byte = ev_flags_r;
      `RX_MASK_IDX:   rd_byte = rx_mask_r;
      `EV_MASK_IDX:   rd_byte = ev_mask_r;
      `CTRL_IDX:      rd_byte = ctrl_r;
      default:        rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Avalon slave: fixed one-cycle wait keeps waitrequest a pure flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r           <= e1_perf_pkg::BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        e1_perf_pkg::BUS_IDLE: begin
          if (i_avs_read || i_avs_write) begin
            state_r           <= e1_perf_pkg::BUS_ACK;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= i_avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
          end
        end
        e1_perf_pkg::BUS_ACK: begin
          state_r           <= e1_perf_pkg::BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  irq_follows_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (|(rx_flags_r & rx_mask_r) && !wr_fire && $stable(rx_mask_r)) |=> o_irq)
    else $error("enabled flag without interrupt");
  mask_blocks_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (rx_mask_r == 8'h00 && ev_mask_r == 8'h00) [*2] |-> !o_irq)
    else $error("interrupt while all masked");
  boundary_period_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(tick_r) |-> $past(tmr_r) >= $past(tmr_lim))
    else $error("boundary before interval end");
  timer_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_r |=> ev_flags_r[`TIMER_FLAG_BIT])
    else $error("timer flag missed boundary");
  crc_inhibit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fas_sync_lost || i_crc_sync_lost) |-> !crc_inc && !feb_inc)
    else $error("crc or e-bit counted during sync loss");
  ebit_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ebit_strobe && !i_fas_sync_lost && !i_crc_sync_lost) |-> feb_inc == !i_ebit)
    else $error("e-bit count mismatch");
  fas_inhibit_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fas_sync_lost || i_sync_search) |-> !fas_inc)
    else $error("alignment error counted while unsynced");
  bpv_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bipolar_violation && !ctrl_r[`VTYPE_BIT] && !ctrl_r[`ZSUB_BIT]) |-> viol_inc)
    else $error("bipolar violation not counted");
  viol_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == e1_perf_pkg::BUS_IDLE && i_avs_read && idx == `VIOL_HI_IDX)
      |=> !o_avs_waitrequest && o_avs_readdata[7:0] == $past(held[0][15:8]))
    else $error("violation high byte misread");

  // ==========================================================
  // Further checks
  viol_lo_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == e1_perf_pkg::BUS_IDLE && i_avs_read && idx == `VIOL_LO_IDX)
      |=> o_avs_readdata[7:0] == $past(held[0][7:0]))
    else $error("violation low byte misread");
  crc_hi_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == e1_perf_pkg::BUS_IDLE && i_avs_read && idx == `CRC_HI_IDX)
      |=> o_avs_readdata[7:0] == $past({held[3][11:6], held[1][9:8]}))
    else $error("crc high byte misread");
  feb_hi_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == e1_perf_pkg::BUS_IDLE && i_avs_read && idx == `FEB_HI_IDX)
      |=> o_avs_readdata[7:0] == $past({held[3][5:0], held[2][9:8]}))
    else $error("e-bit high byte misread");
  ack_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  first_mark_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mark && !seen_mark_r) |-> !bipolar_violation)
    else $error("first mark after reset taken as violation");
  zsub_skip_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bipolar_violation && subst_v && !ctrl_r[`VTYPE_BIT]) |-> !viol_inc)
    else $error("substitution violation counted");
  code_only_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctrl_r[`VTYPE_BIT] |-> viol_inc == cv)
    else $error("code violation count mismatch");
  crc_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_crc_error && !i_fas_sync_lost && !i_crc_sync_lost) |-> crc_inc)
    else $error("crc error not counted in sync");
  fas_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fas_word_error && !i_fas_sync_lost && !i_sync_search) |-> fas_inc)
    else $error("alignment error not counted in sync");
  rx_mask_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_fire && hit(idx, `RX_MASK_IDX)) |=> rx_mask_r == $past(i_avs_writedata[7:0]))
    else $error("receive mask write lost");
  ev_mask_wr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_fire && hit(idx, `EV_MASK_IDX)) |=> ev_mask_r == $past(i_avs_writedata[7:0]))
    else $error("event mask write lost");
  flag_set_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rx_status_events != 8'h00)
      |=> (rx_flags_r & $past(i_rx_status_events)) == $past(i_rx_status_events))
    else $error("receive event lost to clear");
  irq_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ((rx_flags_nxt & rx_mask_r) == 8'h00 && (ev_flags_nxt & ev_mask_r) == 8'h00) |=> !o_irq)
    else $error("interrupt without enabled flag");
  timer_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tmr_r <= LONG_LIM)
    else $error("interval timer overran");
endmodule // e1_perf_monitor
`default_nettype wire

// >>> core/e1_perf_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the E1
  performance monitor. Assumes a 20 MHz system clock and 32-bit Avalon-MM
  register access, one register per aligned word.
*/
// How it works
// - Receive mask register enables eight receive status events, bit 7 to bit 0.
// - Second mask register enables eight frame and timer events, bit 7 to bit 0.
// - Mask bit zero blocks its event, one lets it interrupt.
// - All counters latch each boundary: one second, or 62.5 ms when selected.
// - Latched counts hold the previous interval until the next boundary.
// - Every counter stops at its maximum and never wraps.
// - Violation count is 16 bits, high byte at 0x00, low at 0x01.
// - Type select zero counts bipolar violations: two same-polarity marks in a row.
// - With zero substitution on, substitution violations are not counted.
// - Type select one counts code violations: successive violations of equal polarity.
// - Violation counter ignores sync loss and stops at 65535.
// - CRC error count is 10 bits: top two at 0x02, low byte 0x03.
// - CRC and E-bit counters stop during frame or CRC multiframe sync loss.
// - E-bit counter adds one for each received E-bit equal to zero.
// - E-bit count is 10 bits: top two at 0x04, low byte 0x05.
// - Bits 7..2 of 0x02 show the top six alignment error bits.
// - Bits 7..2 of 0x04 show the low six alignment error bits.
// - Alignment error counter stops during frame sync loss and alignment search.
// - Interval timer flag sets at every boundary.
`ifndef E1_PERF_CONSTS_SVH
`define E1_PERF_CONSTS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define VIOL_HI_IDX     7'h00
`define VIOL_LO_IDX     7'h01
`define CRC_HI_IDX      7'h02
`define CRC_LO_IDX      7'h03
`define FEB_HI_IDX      7'h04
`define FEB_LO_IDX      7'h05
`define RX_STATUS_IDX   7'h06
`define EV_STATUS_IDX   7'h07
`define RX_MASK_IDX     7'h16
`define EV_MASK_IDX     7'h17
`define CTRL_IDX        7'h1a

// ==========================================================
// Control fields and reset values
`define SHORT_SEL_BIT   7
`define VTYPE_BIT       6
`define ZSUB_BIT        2
`define TIMER_FLAG_BIT  4
`define CTRL_RESET      8'h00
`define MASK_RESET      8'h00

// ==========================================================
// Timing
`define CLK_PERIOD_NS       50
`define LONG_INTERVAL_NS    1000000000
`define SHORT_INTERVAL_US   62500

`endif

// >>> core/e1_perf_pkg.sv
/*
  Types shared by the performance monitor modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package e1_perf_pkg;
  typedef logic [15:0] count_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage

// >>> core/err_count_if.sv
/*
  Link between the monitor core and one saturating counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface err_count_if;
  logic                 inc;
  logic                 boundary;
  e1_perf_pkg::count_t  held;
  modport ctrl    (output inc, output boundary, input held);
  modport counter (input inc, input boundary, output held);
endinterface
`default_nettype wire

// >>> core/sat_counter.sv
/*
  Saturating error counter with an interval latch.
  Assumes inc and boundary are single-cycle strobes on i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sat_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic   i_clk,
  input  wire logic   i_sys_rst,
  err_count_if.counter port
);
  localparam e1_perf_pkg::count_t MAX = 16'((32'd1 << WIDTH) - 32'd1);

  e1_perf_pkg::count_t run_r;
  e1_perf_pkg::count_t run_nxt;

  // ==========================================================
  // Running count
  always_comb begin
    run_nxt = run_r;
    if (port.inc && run_r != MAX) begin
      run_nxt = run_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run_r <= 16'h0000;
    end else if (port.boundary) begin
      run_r <= 16'h0000;
    end else begin
      run_r <= run_nxt;
    end
  end

  // Event in the boundary cycle belongs to the closing interval
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      port.held <= 16'h0000;
    end else if (port.boundary) begin
      port.held <= run_nxt;
    end
  end

  // ==========================================================
  // Checks
  sat_stop_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (run_r == MAX && port.inc && !port.boundary) |=> run_r == MAX)
    else $error("counter wrapped past maximum");
  held_stable_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !port.boundary |=> $stable(port.held))
    else $error("held count changed between boundaries");
endmodule // sat_counter
`default_nettype wire

// >>> bench/host_model.sv
/*
  Host processor model: an Avalon-MM master offering one access task.
  Assumes a slave that lowers waitrequest for one cycle per access.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output logic [8:0]       o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  output logic [3:0]       o_byteenable
);
  int unsigned hangs = 0;
  initial begin
    o_address    = 9'h000;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h00000000;
    o_byteenable = 4'h0;
  end
  // ==========================================================
  // Bus cycle: request held until waitrequest sampled low
  task automatic access(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                        input logic [3:0] be, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    o_address    <= {idx, 2'b00};
    o_writedata  <= {24'h000000, d};
    o_byteenable <= be;
    o_read       <= !wr;
    o_write      <= wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 100);
    q = i_readdata[7:0];
    if (n >= 100) hangs++;
    o_read  <= 1'b0;
    o_write <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// >>> bench/e1_error_counters_irq_masks_bench.sv
/*
  Self-checking bench of the E1 performance monitor: masks, flags, interrupt
  and the four interval counters. Assumes short interval parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "e1_perf_consts.svh"
module e1_error_counters_irq_masks_bench;
  localparam int unsigned LONG  = 2000;
  localparam int unsigned SHORT = 300;
  logic        clk, sys_rst, rd_req, wr_req, waitreq, irq;
  logic [8:0]  address;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic        bit_valid, pos, neg, crc_err, eb_stb, eb, fas_err, fas_lost, crc_lost, search;
  logic [7:0]  rx_ev, fr_ev;
  int unsigned miscompares = 0;
  int unsigned samples_checked = 0;
  longint      t_tick;

  e1_perf_monitor #(.LONG_CYCLES(LONG), .SHORT_CYCLES(SHORT)) u_dut (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_avs_address(address), .i_avs_read(rd_req),
    .i_avs_write(wr_req), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_rx_bit_valid(bit_valid),
    .i_rx_pos(pos), .i_rx_neg(neg), .i_crc_error(crc_err), .i_ebit_strobe(eb_stb),
    .i_ebit(eb), .i_fas_word_error(fas_err), .i_fas_sync_lost(fas_lost),
    .i_crc_sync_lost(crc_lost), .i_sync_search(search), .i_rx_status_events(rx_ev),
    .i_frame_events(fr_ev), .o_irq(irq));
  host_model u_host (
    .i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata), .o_address(address),
    .o_read(rd_req), .o_write(wr_req), .o_writedata(wdata), .o_byteenable(be));

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    u_host.access(1'b1, idx, d, 4'hf, q);
  endtask
  task automatic rd_check(input logic [6:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    u_host.access(1'b0, idx, 8'h00, 4'hf, q);
    check({24'h0, q}, {24'h0, exp});
  endtask
  task automatic stop_test();
    miscompares += u_host.hangs;
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Timer flag doubles as the interval marker; irq enabled on it alone
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 3 * LONG);
    if (n >= 3 * LONG) miscompares++;
    t_tick = $time;
    wr(`EV_STATUS_IDX, 8'h10);
  endtask
  task automatic pulse_events(input logic [7:0] r, input logic [7:0] f);
    @(posedge clk);
    rx_ev <= r;
    fr_ev <= f;
    @(posedge clk);
    rx_ev <= 8'h00;
    fr_ev <= 8'h00;
    @(negedge clk);
  endtask
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk);
      bit_valid <= 1'b1;
      pos       <= s[i] == "+";
      neg       <= s[i] == "-";
      @(posedge clk);
      bit_valid <= 1'b0;
    end
  endtask
  task automatic pulse_errs(input int n, input logic c, input logic e, input logic v, input logic f);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      crc_err <= c;
      eb_stb  <= e;
      eb      <= v;
      fas_err <= f;
    end
    @(posedge clk);
    crc_err <= 1'b0;
    eb_stb  <= 1'b0;
    fas_err <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_regs();
    logic [7:0] q;
    rd_check(`RX_MASK_IDX, `MASK_RESET);
    rd_check(`EV_MASK_IDX, `MASK_RESET);
    rd_check(`CTRL_IDX, `CTRL_RESET);
    rd_check(7'h30, 8'h00);
    wr(`RX_MASK_IDX, 8'ha5);
    wr(`EV_MASK_IDX, 8'h5a);
    wr(`VIOL_LO_IDX, 8'hff);
    u_host.access(1'b1, `RX_MASK_IDX, 8'hff, 4'he, q);
    rd_check(`RX_MASK_IDX, 8'ha5);
    rd_check(`EV_MASK_IDX, 8'h5a);
    rd_check(`VIOL_LO_IDX, 8'h00);
    wr(`RX_MASK_IDX, 8'h00);
    wr(`EV_MASK_IDX, 8'h00);
    $display("test_regs done");
  endtask
  task automatic irq_bit(input logic ev, input int i);
    logic [7:0] b;
    b = 8'h01 << i;
    wr(ev ? `EV_STATUS_IDX : `RX_STATUS_IDX, 8'hff);
    wr(ev ? `EV_MASK_IDX : `RX_MASK_IDX, b);
    pulse_events(ev ? 8'h00 : ~b, ev ? ~b : 8'h00);
    check({31'h0, irq}, 32'h0);
    pulse_events(ev ? 8'h00 : b, ev ? b : 8'h00);
    check({31'h0, irq}, 32'h1);
    wr(ev ? `EV_STATUS_IDX : `RX_STATUS_IDX, 8'hff);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    wr(ev ? `EV_MASK_IDX : `RX_MASK_IDX, 8'h00);
  endtask
  // Every violation in these streams is negative, so code mode counts each
  task automatic test_viol(input logic [7:0] ctrl, input logic [7:0] exp);
    longint t0;
    wr(`CTRL_IDX, ctrl);
    send_line("-");
    wait_tick();
    t0 = t_tick;
    fas_lost <= 1'b1;
    send_line("+--00-+");
    wait_tick();
    check(32'((t_tick - t0) / 50), ctrl[7] ? SHORT : LONG);
    rd_check(`VIOL_HI_IDX, 8'h00);
    rd_check(`VIOL_LO_IDX, exp);
    send_line("-+--00-+");
    rd_check(`VIOL_LO_IDX, exp);
    fas_lost <= 1'b0;
    $display("test_viol %h done", ctrl);
  endtask
  task automatic test_errs();
    wr(`CTRL_IDX, 8'h00);
    wait_tick();
    wait_tick();
    pulse_errs(260, 1'b1, 1'b0, 1'b0, 1'b0);
    pulse_errs(257, 1'b0, 1'b1, 1'b0, 1'b0);
    pulse_errs(3, 1'b0, 1'b1, 1'b1, 1'b0);
    pulse_errs(70, 1'b0, 1'b0, 1'b0, 1'b1);
    crc_lost <= 1'b1;
    pulse_errs(5, 1'b1, 1'b1, 1'b0, 1'b0);
    crc_lost <= 1'b0;
    fas_lost <= 1'b1;
    pulse_errs(5, 1'b1, 1'b1, 1'b0, 1'b1);
    fas_lost <= 1'b0;
    search   <= 1'b1;
    pulse_errs(5, 1'b0, 1'b0, 1'b0, 1'b1);
    search   <= 1'b0;
    wait_tick();
    rd_check(`CRC_HI_IDX, 8'h05);
    rd_check(`CRC_LO_IDX, 8'h04);
    rd_check(`FEB_HI_IDX, 8'h19);
    rd_check(`FEB_LO_IDX, 8'h01);
    $display("test_errs done");
  endtask
  // Pulses fit inside one long interval, so the CRC counter must pin at 1023
  task automatic test_sat();
    pulse_errs(1030, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_tick();
    rd_check(`CRC_HI_IDX, 8'h03);
    rd_check(`CRC_LO_IDX, 8'hff);
    $display("test_sat done");
  endtask

  // ==========================================================
  // Clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    {bit_valid, pos, neg, crc_err, eb_stb, eb, fas_err, fas_lost, crc_lost, search} = 10'h000;
    rx_ev = 8'h00;
    fr_ev = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    test_regs();
    for (int i = 0; i < 8; i++) irq_bit(1'b0, i);
    for (int i = 0; i < 8; i++) irq_bit(1'b1, i);
    $display("test_irq done");
    wr(`EV_STATUS_IDX, 8'hff);
    wr(`EV_MASK_IDX, 8'h10);
    test_viol(8'h00, 8'h02);
    test_viol(8'h04, 8'h01);
    test_viol(8'h40, 8'h02);
    test_viol(8'h80, 8'h02);
    test_errs();
    test_sat();
    stop_test();
  end
endmodule // e1_error_counters_irq_masks_bench
`default_nettype wire
